// >>> rtl/opmode_consts.svh
`ifndef OPMODE_CONSTS_SVH
`define OPMODE_CONSTS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
// Address of the mode-select register.
`define OPM_ADDR 8'h26
// Reset value: both chains off, which is standby, and the 4 g range.
`define OPM_RESET 8'h00

// ------------------------------------------------------------
// Field positions inside the mode-select register
// ------------------------------------------------------------
`define OPM_DSM_LSB 0
`define OPM_DSM_MSB 1
`define OPM_SAR_LSB 2
`define OPM_SAR_MSB 3
`define OPM_RANGE_LSB 4
`define OPM_RANGE_MSB 5

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
// Output settling time after entering measurement, in microseconds.
`define SETTLE_TIME_US 2000
// Clock rate in MHz.
`define CLK_FREQ_MHZ 40
// Settling time in clock cycles.
`define SETTLE_CYCLES (`SETTLE_TIME_US * `CLK_FREQ_MHZ)

`endif

// >>> rtl/opmode_ctrl.sv
`timescale 1ns/1ps
`include "opmode_consts.svh"

// Behaviour
// - Seven modes: standby plus six measurement.
// - Three fast modes use sigma-delta chain.
// - Three thrifty modes use successive-approx chain.
// - Standby stops every chain.
// - Standby keeps FIFO, blocks new interrupts.
// - Reset leaves the block in standby.
// - One chain of each kind may run together.
// - Ranges of 4, 8 and 16 g.
// - Samples scale with selected range.
// - Mode chosen by register at 0x26.
// - Twelve-bit temperature reading provided.
// - Data to config port or audio pins.
// - Second audio pin: master clock or data.
// - First audio pin carries data channel 0.
module opmode_ctrl #(
   parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic NRST,
   // Register port from the serial configuration interface.
   input wire logic REG_WE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // Converter samples.
   input wire logic DSM_VALID,
   input wire logic [15:0] DSM_SAMPLE,
   input wire logic SAR_VALID,
   input wire logic [11:0] SAR_SAMPLE,
   input wire logic [11:0] TEMP_SAMPLE,
   // Audio pin configuration and sources.
   input wire logic [1:0] AUDIO_FMT,
   input wire logic PIN_B_IS_CLOCK,
   input wire logic AUD_DATA0,
   input wire logic AUD_DATA1,
   input wire logic AUD_MCLK,
   // Chain control.
   output logic SIGMA_DELTA_CHAIN_EN,
   output logic SUCCESSIVE_APPROX_CHAIN_EN,
   output logic [1:0] DSM_MODE,
   output logic [1:0] SAR_MODE,
   output logic [1:0] RANGE_SEL,
   output logic FILTER_CLEAR,
   // Status and data.
   output logic MEASURING,
   output logic SETTLED,
   output logic FIFO_WR_EN,
   output logic IRQ_EN,
   output logic ACCEL_VALID,
   output logic [15:0] ACCEL_DATA,
   output logic [11:0] TEMP_DATA,
   // Audio pins.
   output logic AUDIO_DATA_OUT_A,
   output logic AUDIO_DATA_OUT_A_OE_N,
   output logic AUDIO_DATA_OUT_B_OR_MASTER_CLOCK,
   output logic AUDIO_DATA_OUT_B_OR_MASTER_CLOCK_OE_N
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // Every register of the block in one record.
   typedef struct packed {
      opmode_pkg::state_t st;
      logic [7:0] opm;
      logic dsm_en;
      logic sar_en;
      logic filt_clr;
      logic settle_go;
      logic fifo_en;
      logic irq_en;
      logic vld;
      logic [15:0] data;
      logic [11:0] temp;
      logic a_o;
      logic a_oe_n;
      logic b_o;
      logic b_oe_n;
      logic [7:0] rdata;
      logic meas; // Registered copy of the measurement flag.
      logic [1:0] rng; // Registered, decoded range selection.
   } ctl_t;

   ctl_t q;
   ctl_t d;
   logic settle_done; // From the settle timer, registered there.
   logic wr_opm; // Write to the mode-select register.

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Sigma-delta field of a mode value.
   function automatic logic [1:0] dsm_field(input logic [7:0] v);
      dsm_field = v[`OPM_DSM_MSB:`OPM_DSM_LSB];
   endfunction

   // Successive-approximation field of a mode value.
   function automatic logic [1:0] sar_field(input logic [7:0] v);
      sar_field = v[`OPM_SAR_MSB:`OPM_SAR_LSB];
   endfunction

   // Range field; the unused code falls back to the widest range.
   function automatic logic [1:0] range_field(input logic [7:0] v);
      logic [1:0] r;
      r = v[`OPM_RANGE_MSB:`OPM_RANGE_LSB];
      range_field = (r == 2'h3) ? opmode_pkg::RANGE_16G : r;
   endfunction

   assign wr_opm = REG_WE && (REG_ADDR == `OPM_ADDR);

   // ------------------------------------------------------------
   // Settling timer
   // ------------------------------------------------------------
   settle_timer #(
      .CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .clk(CLK),
      .nrst(NRST),
      .start(q.settle_go),
      .run(q.st != opmode_pkg::ST_STANDBY),
      .done(settle_done)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // One process computes every register; pulses default low.
   always_comb
   begin
      d = q;
      d.filt_clr = 1'b0;
      d.settle_go = 1'b0;
      d.vld = 1'b0;
      // A write lands at the end of its cycle; the new mode acts from then on.
      if (wr_opm)
      begin
         d.opm = REG_WDATA;
         // Fresh filter state for the chains of the newly chosen mode.
         d.filt_clr = 1'b1;
         // Both fields zero means standby, anything else is measurement.
         if ((dsm_field(REG_WDATA) == 2'h0) && (sar_field(REG_WDATA) == 2'h0))
            d.st = opmode_pkg::ST_STANDBY;
         else
         begin
            d.st = opmode_pkg::ST_SETTLE;
            d.settle_go = 1'b1;
         end
      end
      else
      begin
         unique case (q.st)
            opmode_pkg::ST_STANDBY:
               d.st = opmode_pkg::ST_STANDBY;
            opmode_pkg::ST_SETTLE:
               // Data is not trusted until settled, except after a write made while measuring, where the old done lets it in after one cycle.
               d.st = settle_done ? opmode_pkg::ST_MEASURE : opmode_pkg::ST_SETTLE;
            opmode_pkg::ST_MEASURE:
               d.st = opmode_pkg::ST_MEASURE;
         endcase
      end
      // Chain enables follow the register; both may run at once.
      d.dsm_en = (d.st != opmode_pkg::ST_STANDBY) && (dsm_field(d.opm) != 2'h0);
      d.sar_en = (d.st != opmode_pkg::ST_STANDBY) && (sar_field(d.opm) != 2'h0);
      // Status copies are registered so that no output leaves through a gate.
      d.meas = (d.st != opmode_pkg::ST_STANDBY);
      d.rng = range_field(d.opm);
      // Standby freezes the FIFO as it is and silences interrupts.
      d.fifo_en = (d.st == opmode_pkg::ST_MEASURE);
      d.irq_en = (d.st == opmode_pkg::ST_MEASURE);
      // Sigma-delta wins when both chains deliver in the same cycle;
      // the narrower result is left-aligned so range scaling is the same.
      if (q.dsm_en && DSM_VALID)
      begin
         d.data = DSM_SAMPLE;
         d.vld = 1'b1;
      end
      else if (q.sar_en && SAR_VALID)
      begin
         d.data = {SAR_SAMPLE, 4'h0};
         d.vld = 1'b1;
      end
      // Temperature is tracked only while measuring.
      if (q.st != opmode_pkg::ST_STANDBY)
         d.temp = TEMP_SAMPLE;
      // Pin A carries channel 0 in the audio formats only.
      d.a_o = AUD_DATA0;
      d.a_oe_n = (AUDIO_FMT == opmode_pkg::FMT_CFG_PORT) || (AUDIO_FMT == 2'h3);
      // Pin B is master clock or channel 1 in I2S/TDM, idle otherwise.
      d.b_o = PIN_B_IS_CLOCK ? AUD_MCLK : AUD_DATA1;
      d.b_oe_n = (AUDIO_FMT != opmode_pkg::FMT_I2S_TDM);
      // Read data; unknown addresses read as zero.
      d.rdata = (REG_ADDR == `OPM_ADDR) ? q.opm : 8'h00;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Reset puts everything in standby with all chains off.
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         q <= '0;
         q.st <= opmode_pkg::ST_STANDBY;
         q.opm <= `OPM_RESET;
         q.a_oe_n <= 1'b1;
         q.b_oe_n <= 1'b1;
      end
      else
         q <= d;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign REG_RDATA = q.rdata;
   assign SIGMA_DELTA_CHAIN_EN = q.dsm_en;
   assign SUCCESSIVE_APPROX_CHAIN_EN = q.sar_en;
   assign DSM_MODE = dsm_field(q.opm);
   assign SAR_MODE = sar_field(q.opm);
   assign RANGE_SEL = q.rng;
   assign FILTER_CLEAR = q.filt_clr;
   assign MEASURING = q.meas;
   assign SETTLED = settle_done;
   assign FIFO_WR_EN = q.fifo_en;
   assign IRQ_EN = q.irq_en;
   assign ACCEL_VALID = q.vld;
   assign ACCEL_DATA = q.data;
   assign TEMP_DATA = q.temp;
   assign AUDIO_DATA_OUT_A = q.a_o;
   assign AUDIO_DATA_OUT_A_OE_N = q.a_oe_n;
   assign AUDIO_DATA_OUT_B_OR_MASTER_CLOCK = q.b_o;
   assign AUDIO_DATA_OUT_B_OR_MASTER_CLOCK_OE_N = q.b_oe_n;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   // A write to the mode register.
   sequence s_mode_write;
      wr_opm;
   endsequence

   // A write selecting standby.
   sequence s_standby_write;
      wr_opm && (REG_WDATA[3:0] == 4'h0);
   endsequence

   a_reset_standby: assert property ($rose(NRST) |-> q.st == opmode_pkg::ST_STANDBY && q.opm == 8'h00)
      else $error("not in standby after reset");
   a_standby_idle: assert property (q.st == opmode_pkg::ST_STANDBY |-> !q.dsm_en && !q.sar_en)
      else $error("chain active in standby");
   a_dsm_select: assert property (s_mode_write ##1 (dsm_field(q.opm) != 2'h0) |-> q.dsm_en)
      else $error("sigma-delta chain not enabled");
   a_sar_select: assert property (s_mode_write ##1 (sar_field(q.opm) != 2'h0) |-> q.sar_en)
      else $error("approximation chain not enabled");
   a_concurrent_run: assert property (s_mode_write ##0 REG_WDATA[1:0] != 2'h0 ##0 REG_WDATA[3:2] != 2'h0
      |=> q.dsm_en && q.sar_en)
      else $error("concurrent mode not honoured");
   a_write_applies: assert property (s_mode_write |=> q.opm == $past(REG_WDATA) && q.filt_clr)
      else $error("mode write not applied");
   a_clear_pulse: assert property (q.filt_clr |=> !q.filt_clr || $past(wr_opm))
      else $error("filter clear held too long");
   a_standby_quiet: assert property (s_standby_write |=> (!q.fifo_en && !q.irq_en) [*2])
      else $error("fifo or interrupt active in standby");
   a_pin_a_off: assert property (AUDIO_FMT == 2'h0 |=> AUDIO_DATA_OUT_A_OE_N)
      else $error("pin A driven in config-port mode");
   a_pin_b_off: assert property (AUDIO_FMT == 2'h2 |=> AUDIO_DATA_OUT_B_OR_MASTER_CLOCK_OE_N)
      else $error("pin B driven in PDM mode");

endmodule // opmode_ctrl

// >>> rtl/opmode_pkg.sv
package opmode_pkg;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   // Sigma-delta chain selection, held in the low two bits.
   typedef enum logic [1:0] {
      DSM_OFF = 2'h0,
      HIGH_PERFORMANCE_MODE = 2'h1,
      REDUCED_BANDWIDTH_MODE = 2'h2,
      LOW_POWER_MODE = 2'h3
   } dsm_sel_t;

   // Successive-approximation chain selection.
   typedef enum logic [1:0] {
      SAR_OFF = 2'h0,
      VERY_LOW_POWER_MODE = 2'h1,
      ULTRA_LOW_POWER_MODE = 2'h2,
      HEART_SOUND_MODE = 2'h3
   } sar_sel_t;

   // Full-scale range codes.
   typedef enum logic [1:0] {
      RANGE_4G = 2'h0,
      RANGE_8G = 2'h1,
      RANGE_16G = 2'h2
   } range_t;

   // Audio pin format.
   typedef enum logic [1:0] {
      FMT_CFG_PORT = 2'h0,
      FMT_I2S_TDM = 2'h1,
      FMT_PDM = 2'h2
   } audio_fmt_t;

   // Block state, one-hot.
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h1,
      ST_SETTLE = 3'h2,
      ST_MEASURE = 3'h4
   } state_t;

endpackage

// >>> rtl/settle_timer.sv
`timescale 1ns/1ps
`include "opmode_consts.svh"

// Counts the settling wait after measurement is entered.
module settle_timer #(
   parameter int unsigned CYCLES = `SETTLE_CYCLES
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Control.
   input wire logic start,
   input wire logic run,
   // Status.
   output logic done
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // The whole timer state.
   typedef struct packed {
      logic [16:0] cnt;
      logic done;
   } tmr_t;

   tmr_t q;
   tmr_t d;

   // Last count value before done is raised.
   localparam logic [16:0] LAST = 17'(CYCLES - 1);

   // Restart wins over counting; a mode written while measuring sees the old done for one cycle and skips the wait.
   always_comb
   begin
      d = q;
      if (start || !run)
      begin
         d.cnt = 17'h00000;
         d.done = 1'b0;
      end
      else if (!q.done)
      begin
         // Count up; done comes out of a register.
         d.cnt = q.cnt + 17'h00001;
         d.done = (q.cnt == LAST);
      end
   end

   // Register the state.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         q <= '0;
      else
         q <= d;
   end

   assign done = q.done;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Done rises only after the full count.
   a_settle_length: assert property (@(posedge clk) disable iff (!nrst)
      $rose(q.done) |-> $past(q.cnt) == LAST)
      else $error("settle done rose early");

endmodule // settle_timer

// >>> tb/host_model.sv
`timescale 1ns/1ps
`include "opmode_consts.svh"

// ------------------------------------------------------------
// Host processor on the configuration port
// ------------------------------------------------------------
module host_model
(
   // Clock.
   input wire logic clk,
   // Register port toward the block.
   output logic reg_we,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // The bus starts idle, with no strobe.
   initial
   begin
      reg_we = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write after an idle gap, so the host can act promptly or slowly.
   // Data is inverted after the strobe, so a stale byte never passes for a held one.
   task automatic write(input logic [7:0] addr, input logic [7:0] data, input int gap);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      reg_we = 1'b1;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge clk);
      reg_we = 1'b0;
      reg_wdata = ~data;
   endtask

   // Reconfiguration passes through standby, so no measurement sees half a change.
   task automatic reconfig(input logic [7:0] data);
      write(`OPM_ADDR, 8'h00, 0);
      write(`OPM_ADDR, data, 0);
   endtask

   // The read byte is registered one edge after the address is shown.
   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      reg_addr = addr;
      @(negedge clk);
      data = reg_rdata;
   endtask

   // Samples are not trusted until the output has settled.
   task automatic settle(input int cycles);
      repeat (cycles) @(negedge clk);
   endtask
endmodule // host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "opmode_consts.svh"

module tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   // Shortened settling count so the run stays brief.
   localparam int unsigned SETTLE = 8;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic reg_we, dsm_valid = 1'b0, sar_valid = 1'b0, pin_b_clk = 1'b0;
   logic aud_d0 = 1'b0, aud_d1 = 1'b0, aud_mclk = 1'b0, dsm_en, sar_en, filter_clear;
   logic measuring, settled, fifo_wr_en, irq_en, accel_valid, a_out, a_oe_n, b_out, b_oe_n;
   logic [1:0] audio_fmt = 2'h0;
   logic [1:0] dsm_mode, sar_mode, range_sel;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [11:0] sar_sample = 12'h000;
   logic [11:0] temp_sample = 12'h123;
   logic [11:0] temp_data;
   logic [15:0] dsm_sample = 16'h0000;
   logic [15:0] accel_data;
   int fail_count = 0;
   int comparisons = 0;
   int cnt;
   // One row: the byte written and the selections it should give.
   typedef struct packed {logic [7:0] wdata; logic [1:0] sigma_delta_chain; logic [1:0] successive_approx_chain; logic [1:0] rng;} row_t;
   row_t rows [10] = '{'{8'h01, 2'h1, 2'h0, 2'h0}, '{8'h02, 2'h2, 2'h0, 2'h0}, '{8'h03, 2'h3, 2'h0, 2'h0},
      '{8'h04, 2'h0, 2'h1, 2'h0}, '{8'h08, 2'h0, 2'h2, 2'h0}, '{8'h0C, 2'h0, 2'h3, 2'h0},
      '{8'h05, 2'h1, 2'h1, 2'h0}, '{8'h1F, 2'h3, 2'h3, 2'h1}, '{8'h2A, 2'h2, 2'h2, 2'h2},
      '{8'h30, 2'h0, 2'h0, 2'h2}};

   // The clock toggles every 12.5 ns half period, giving a 25 ns period.
   always #12.5 clk = ~clk;

   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   opmode_ctrl #(.SETTLE_CYCLES(SETTLE)) opmode_ctrl_i (.CLK(clk), .NRST(nrst), .REG_WE(reg_we),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .DSM_VALID(dsm_valid),
      .DSM_SAMPLE(dsm_sample), .SAR_VALID(sar_valid), .SAR_SAMPLE(sar_sample), .TEMP_SAMPLE(temp_sample),
      .AUDIO_FMT(audio_fmt), .PIN_B_IS_CLOCK(pin_b_clk), .AUD_DATA0(aud_d0), .AUD_DATA1(aud_d1),
      .AUD_MCLK(aud_mclk), .SIGMA_DELTA_CHAIN_EN(dsm_en), .SUCCESSIVE_APPROX_CHAIN_EN(sar_en),
      .DSM_MODE(dsm_mode), .SAR_MODE(sar_mode), .RANGE_SEL(range_sel), .FILTER_CLEAR(filter_clear),
      .MEASURING(measuring), .SETTLED(settled), .FIFO_WR_EN(fifo_wr_en), .IRQ_EN(irq_en),
      .ACCEL_VALID(accel_valid), .ACCEL_DATA(accel_data), .TEMP_DATA(temp_data), .AUDIO_DATA_OUT_A(a_out),
      .AUDIO_DATA_OUT_A_OE_N(a_oe_n), .AUDIO_DATA_OUT_B_OR_MASTER_CLOCK(b_out),
      .AUDIO_DATA_OUT_B_OR_MASTER_CLOCK_OE_N(b_oe_n));
   host_model host_model_i (.clk(clk), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Case equality keeps an unknown from passing as a match.
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic test_done;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Reset is held for five cycles, then the idle state is checked.
   task automatic do_reset;
      @(negedge clk);
      nrst = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      chk("measuring", 1'b0, measuring);
      chk("chain_en", 2'h0, {dsm_en, sar_en});
      chk("settled", 1'b0, settled);
      chk("pin_oe_n", 2'h3, {a_oe_n, b_oe_n});
      host_model_i.read(`OPM_ADDR, rd);
      chk("mode_reg", `OPM_RESET, rd);
   endtask

   // One sample strobe; the pulse is polled for a few cycles, then must drop.
   task automatic sample(input logic is_sar, input logic [15:0] val, input logic [15:0] exp, input logic hit);
      @(negedge clk);
      dsm_sample = val;
      sar_sample = val[11:0];
      dsm_valid = ~is_sar;
      sar_valid = is_sar;
      @(negedge clk);
      dsm_valid = 1'b0;
      sar_valid = 1'b0;
      cnt = 0;
      while (accel_valid !== 1'b1 && cnt < 3)
      begin
         @(negedge clk);
         cnt++;
      end
      chk("accel_valid", hit, accel_valid);
      // A dropped sample must leave the last data word untouched.
      chk("accel_data", exp, accel_data);
      if (hit)
      begin
         @(negedge clk);
         chk("accel_pulse", 1'b0, accel_valid);
      end
   endtask

   // Pin values seen two cycles after the sources; bits are A, A enable, B, B enable.
   task automatic aud(input logic [1:0] fmt, input logic [3:0] src, input logic [3:0] exp, input logic [3:0] mask);
      audio_fmt = fmt;
      {pin_b_clk, aud_d0, aud_d1, aud_mclk} = src;
      repeat (2) @(negedge clk);
      chk("audio_pins", exp, {a_out, a_oe_n, b_out, b_oe_n} & mask);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      do_reset();
      // Every mode and range through a table.
      foreach (rows[i])
      begin
         host_model_i.reconfig(rows[i].wdata);
         chk("filter_clear", 1'b1, filter_clear);
         chk("dsm_mode", rows[i].sigma_delta_chain, dsm_mode);
         chk("sar_mode", rows[i].successive_approx_chain, sar_mode);
         chk("range_sel", rows[i].rng, range_sel);
         chk("chain_en", {rows[i].sigma_delta_chain != 2'h0, rows[i].successive_approx_chain != 2'h0}, {dsm_en, sar_en});
         chk("measuring", (rows[i].sigma_delta_chain | rows[i].successive_approx_chain) != 2'h0, measuring);
      end
      // Concurrent mode: capture opens only after the settling count.
      host_model_i.reconfig(8'h05);
      chk("fifo_early", 1'b0, fifo_wr_en);
      cnt = 0;
      while (settled !== 1'b1 && cnt < 40)
      begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= 40)
      begin
         fail_count++;
         test_done();
      end
      // The count starts in the cycle after the write edge and the timer starts one edge later.
      chk("settle_len", 16'(SETTLE + 1), 16'(cnt));
      chk("fifo_early", 1'b0, fifo_wr_en);
      @(negedge clk);
      chk("capture_en", 2'h3, {fifo_wr_en, irq_en});
      host_model_i.settle(2);
      sample(1'b0, 16'hA5C3, 16'hA5C3, 1'b1);
      sample(1'b1, 16'h0ABC, 16'hABC0, 1'b1);
      chk("temp_data", 12'h123, temp_data);
      // Standby stops capture, drops samples and freezes the temperature.
      host_model_i.write(`OPM_ADDR, 8'h00, 1);
      chk("standby", 5'h00, {measuring, dsm_en, sar_en, fifo_wr_en, irq_en});
      sample(1'b0, 16'h1234, 16'hABC0, 1'b0);
      temp_sample = 12'h456;
      repeat (2) @(negedge clk);
      chk("temp_hold", 12'h123, temp_data);
      // An unmapped address is ignored and reads zero.
      host_model_i.write(8'h27, 8'h05, 0);
      chk("measuring", 1'b0, measuring);
      host_model_i.read(8'h27, rd);
      chk("unmapped_rd", 8'h00, rd);
      host_model_i.write(`OPM_ADDR, 8'hD0, 0);
      host_model_i.read(`OPM_ADDR, rd);
      chk("mode_reg", 8'hD0, rd);
      chk("range_sel", 2'h1, range_sel);
      // Audio pin multiplexing for each format.
      aud(2'h1, 4'hD, 4'hA, 4'hF);
      aud(2'h1, 4'h2, 4'h2, 4'hF);
      aud(2'h2, 4'hF, 4'h9, 4'hD);
      aud(2'h0, 4'hF, 4'h5, 4'h5);
      aud(2'h3, 4'hF, 4'h5, 4'h5);
      // A second reset in mid-measurement returns the block to standby.
      host_model_i.reconfig(8'h0F);
      do_reset();
      test_done();
   end
endmodule // tb
